// [rtl/meid_top.sv]
// Dual-mode monitor identification memory: mode logic, memory and bus slave.
// Assumes an external pull-up on SDA and SCL; the host makes every link clock.
//
// Overview of operation
// RULE1 - After reset the device starts in stream mode, never entered otherwise.
// RULE2 - Nine stream-clock cycles are counted before any data goes out.
// RULE3 - SDA stays released during the nine synchronisation cycles.
// RULE4 - First bit driven on the tenth rising stream edge, most significant first.
// RULE5 - Stream SDA changes only after the rising edge, steady through low phase.
// RULE6 - Eight data bits per byte, then one pulse with SDA released.
// RULE7 - After byte 127 the stream continues straight with byte 0.
// RULE8 - Host finds the array start by counting bytes, clocks or a pattern.
// RULE9 - Host generates the stream clock; the device only receives it.
// RULE10 - A low pulse on SCL moves the device into bus mode, SDA then listens.
// RULE11 - Bus mode is kept until the next reset.
// RULE12 - In bus mode the device is a serial bus slave waiting for commands.
// RULE13 - SDA changes only while SCL is low; SDA edges at SCL high are START/STOP.
// RULE14 - In bus mode the host alone generates SCL.
// RULE15 - Programming only in bus mode and with the write-protect pin high.
// RULE16 - Write protection depends on the write-protect pin only, not stream clock.
// RULE17 - Factory test strap held low puts the device into test mode.
// RULE18 - Bus mode offers addressed byte reads and writes over all 128 bytes.
`timescale 1ns/1ps
`default_nettype none
module meid_top #(
    parameter logic [6:0] DEV_ADDR = meid_pkg::SLAVE_ADDR
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stream_clock,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic write_protect_low,
    input wire logic factory_test_strap,
    output logic sda_o,
    output logic sda_oe,
    output logic bus_mode_active,
    output logic test_mode_active
);
    import meid_pkg::*;

    typedef enum logic [2:0] {
        BS_IDLE,
        BS_DEVADDR,
        BS_ACK_DEV,
        BS_WORDADDR,
        BS_ACK_WORD,
        BS_WRITE,
        BS_ACK_WRITE,
        BS_READ
    } meid_bus_state_t;

    // Pin synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] wp_sync;
    logic [1:0] strap_sync;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    // Mode and strap
    logic bus_mode;
    logic test_mode;
    logic strap_taken;
    logic [SWITCH_CNT_W-1:0] low_cnt;

    // Stream crossing
    logic [1:0] req_sync;
    logic [1:0] pull_sync;
    logic req_seen;
    logic [BYTE_W-1:0] data_hold;

    // Bus slave
    meid_bus_state_t bstate;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [BYTE_W-1:0] rx_shift;
    logic [BYTE_W-1:0] tx_shift;
    logic [ADDR_W-1:0] ptr;
    logic read_cmd;
    logic bus_pull;
    logic write_allowed;
    logic write_now;
    logic byte_done;
    logic addr_match;

    logic [BYTE_W-1:0] mem [MEM_BYTES];

    meid_xfer_if link ();

    meid_stream_tx u_stream (
        .stream_clock(stream_clock),
        .sys_rst(sys_rst),
        .link(link.stream)
    );

    // Memory holds no reset; it starts erased like a blank part
    initial begin
        for (int i = 0; i < MEM_BYTES; i++) begin
            mem[i] = ERASED_BYTE;
        end
    end

    always_ff @(posedge clk) begin
        scl_sync <= {scl_sync[0], scl_i};
        sda_sync <= {sda_sync[0], sda_i};
        wp_sync <= {wp_sync[0], write_protect_low};
        strap_sync <= {strap_sync[0], factory_test_strap};
        req_sync <= {req_sync[0], link.req_toggle};
        pull_sync <= {pull_sync[0], link.pull_low};
    end

    assign scl_s = scl_sync[1];
    assign sda_s = sda_sync[1];

    // Delayed copies for edge detection read only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s; // [RULE13]
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s; // [RULE13]

    // Strap caught once after reset release, not under the reset itself
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            strap_taken <= 1'b0;
            test_mode <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            test_mode <= ~strap_sync[1]; // [RULE17]
        end
    end

    // Mode switch: SCL held low long enough while still streaming
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_mode <= 1'b0; // [RULE1]
            low_cnt <= '0;
        end else if (!bus_mode) begin
            if (scl_s) begin
                low_cnt <= '0;
            end else if (low_cnt == SWITCH_CNT_W'(SWITCH_LOW_CYCLES - 1)) begin
                bus_mode <= 1'b1; // [RULE10]
            end else begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    // Byte fetch for the stream side; answer toggles in the same cycle the data is loaded
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_seen <= 1'b0;
            data_hold <= ERASED_BYTE;
        end else if (req_sync[1] != req_seen) begin
            data_hold <= mem[link.req_addr]; // [RULE7]
            req_seen <= req_sync[1];
        end
    end

    assign link.ack_toggle = req_seen;
    assign link.byte_data = data_hold;
    assign link.bus_mode = bus_mode;

    // Only the protect pin and the mode matter; stream clock plays no part
    assign write_allowed = bus_mode & wp_sync[1]; // [RULE15] [RULE16]
    assign byte_done = scl_fall && bit_cnt == BIT_CNT_W'(BITS_PER_BYTE);
    assign write_now = bstate == BS_WRITE && byte_done && write_allowed; // [RULE15]
    assign addr_match = rx_shift[BYTE_W-1:1] == DEV_ADDR;

    // Plain always: the erased image is loaded by the initial block above
    always @(posedge clk) begin
        if (write_now) begin
            mem[ptr] <= rx_shift; // [RULE18]
        end
    end

    // Bus slave: sample on SCL rise, drive only after SCL fall
    always_ff @(posedge clk) begin
        if (sys_rst || !bus_mode || test_mode) begin
            bstate <= BS_IDLE;
            bit_cnt <= '0;
            rx_shift <= '0;
            tx_shift <= ERASED_BYTE;
            ptr <= '0;
            read_cmd <= 1'b0;
            bus_pull <= 1'b0;
        end else if (start_cond) begin
            // Repeated start keeps the pointer for a random read
            bstate <= BS_DEVADDR; // [RULE12]
            bit_cnt <= '0;
            bus_pull <= 1'b0;
        end else if (stop_cond) begin
            bstate <= BS_IDLE;
            bus_pull <= 1'b0;
        end else begin
            unique case (bstate)
                BS_IDLE: begin
                    bus_pull <= 1'b0; // [RULE12]
                end
                BS_DEVADDR, BS_WORDADDR, BS_WRITE: begin
                    if (scl_rise && bit_cnt < BIT_CNT_W'(BITS_PER_BYTE)) begin
                        rx_shift <= {rx_shift[BYTE_W-2:0], sda_s};
                        bit_cnt <= bit_cnt + 1'b1;
                    end else if (byte_done) begin
                        bit_cnt <= '0;
                        if (bstate == BS_DEVADDR) begin
                            if (addr_match) begin
                                read_cmd <= rx_shift[0];
                                bus_pull <= 1'b1; // [RULE13]
                                bstate <= BS_ACK_DEV;
                            end else begin
                                bstate <= BS_IDLE;
                            end
                        end else if (bstate == BS_WORDADDR) begin
                            ptr <= rx_shift[ADDR_W-1:0]; // [RULE18]
                            bus_pull <= 1'b1;
                            bstate <= BS_ACK_WORD;
                        end else begin
                            // Protected writes are still acknowledged but dropped
                            ptr <= ptr + 1'b1;
                            bus_pull <= 1'b1;
                            bstate <= BS_ACK_WRITE;
                        end
                    end
                end
                BS_ACK_DEV: begin
                    if (scl_fall) begin
                        if (read_cmd) begin
                            tx_shift <= {mem[ptr][BYTE_W-2:0], 1'b1};
                            bus_pull <= ~mem[ptr][BYTE_W-1]; // [RULE13] [RULE18]
                            ptr <= ptr + 1'b1;
                            bit_cnt <= BIT_CNT_W'(1);
                            bstate <= BS_READ;
                        end else begin
                            bus_pull <= 1'b0;
                            bstate <= BS_WORDADDR;
                        end
                    end
                end
                BS_ACK_WORD, BS_ACK_WRITE: begin
                    if (scl_fall) begin
                        bus_pull <= 1'b0;
                        bstate <= BS_WRITE;
                    end
                end
                BS_READ: begin
                    if (scl_rise && bit_cnt == '0) begin
                        // Host acknowledge decides whether the read goes on
                        if (sda_s) begin
                            bstate <= BS_IDLE;
                        end
                    end else if (scl_fall) begin
                        if (bit_cnt == '0) begin
                            tx_shift <= {mem[ptr][BYTE_W-2:0], 1'b1};
                            bus_pull <= ~mem[ptr][BYTE_W-1]; // [RULE13]
                            ptr <= ptr + 1'b1;
                            bit_cnt <= BIT_CNT_W'(1);
                        end else if (bit_cnt == BIT_CNT_W'(BITS_PER_BYTE)) begin
                            bus_pull <= 1'b0;
                            bit_cnt <= '0;
                        end else begin
                            bus_pull <= ~tx_shift[BYTE_W-1]; // [RULE13]
                            tx_shift <= {tx_shift[BYTE_W-2:0], 1'b1};
                            bit_cnt <= bit_cnt + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // Output stage: one flop per pin signal, open drain only pulls low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sda_oe <= 1'b0; // [RULE3]
            sda_o <= 1'b0;
            bus_mode_active <= 1'b0;
            test_mode_active <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            // Test mode keeps the pin released in both modes
            sda_oe <= ~test_mode & (bus_mode ? bus_pull : pull_sync[1]); // [RULE5] [RULE17]
            bus_mode_active <= bus_mode;
            test_mode_active <= test_mode;
        end
    end
endmodule
`default_nettype wire

// [rtl/meid_pkg.sv]
// Constants for the dual-mode monitor identification memory.
// Assumes a 100 MHz system clock and a host-driven stream clock.
package meid_pkg;
    // Memory geometry
    localparam int MEM_BYTES = 128;
    localparam int ADDR_W = 7;
    localparam int BYTE_W = 8;

    // Stream framing
    localparam int SYNC_CYCLES = 9;
    localparam int BITS_PER_BYTE = 8;
    localparam int STREAM_CNT_W = 4;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MODE_SWITCH_PULSE_WIDTH_NS = 500;
    // A quarter of the typical width still counts as a switch pulse
    localparam int SWITCH_LOW_NS = MODE_SWITCH_PULSE_WIDTH_NS / 4;
    localparam int SWITCH_LOW_CYCLES = (SWITCH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWITCH_CNT_W = 8;

    // Serial bus slave
    localparam logic [6:0] SLAVE_ADDR = 7'h50;
    localparam int BIT_CNT_W = 4;

    // Memory content before any programming
    localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hff;
endpackage

// [rtl/meid_xfer_if.sv]
// Carrier between the system-clock core and the stream-clock transmitter.
// Request/acknowledge are toggles; address and data stay stable across each handshake.
`timescale 1ns/1ps
`default_nettype none
interface meid_xfer_if;
    import meid_pkg::*;
    logic req_toggle;
    logic [ADDR_W-1:0] req_addr;
    logic ack_toggle;
    logic [BYTE_W-1:0] byte_data;
    logic bus_mode;
    logic pull_low;

    modport stream (
        output req_toggle,
        output req_addr,
        output pull_low,
        input ack_toggle,
        input byte_data,
        input bus_mode
    );
    modport core (
        input req_toggle,
        input req_addr,
        input pull_low,
        output ack_toggle,
        output byte_data,
        output bus_mode
    );
endinterface
`default_nettype wire

// [rtl/meid_stream_tx.sv]
// Continuous stream transmitter, clocked by the host's stream clock.
// Assumes the core answers each byte request well within one byte time.
`timescale 1ns/1ps
`default_nettype none
module meid_stream_tx (
    input wire logic stream_clock,
    input wire logic sys_rst,
    meid_xfer_if.stream link
);
    import meid_pkg::*;

    typedef enum logic [1:0] {ST_SYNC, ST_BITS, ST_GAP, ST_OFF} meid_stream_state_t;

    logic [1:0] rst_sync;
    logic [1:0] mode_sync;
    logic [1:0] ack_sync;
    logic srst;
    logic bus_mode_s;
    logic ack_s;
    logic do_load;
    meid_stream_state_t state;
    logic [STREAM_CNT_W-1:0] cnt;
    logic [BYTE_W-1:0] shreg;
    logic [ADDR_W-1:0] addr;
    logic req;
    logic pull;

    always_ff @(posedge stream_clock) begin
        rst_sync <= {rst_sync[0], sys_rst};
        mode_sync <= {mode_sync[0], link.bus_mode};
        ack_sync <= {ack_sync[0], link.ack_toggle};
    end

    assign srst = rst_sync[1];
    assign bus_mode_s = mode_sync[1];
    assign ack_s = ack_sync[1];

    // Tenth edge after power-up, or the edge after each gap pulse
    assign do_load = (state == ST_SYNC && cnt == STREAM_CNT_W'(SYNC_CYCLES)) || state == ST_GAP; // [RULE4]

    always_ff @(posedge stream_clock) begin
        if (srst) begin
            state <= ST_SYNC; // [RULE1]
            cnt <= '0;
            shreg <= ERASED_BYTE;
            addr <= '0;
            req <= 1'b0;
            pull <= 1'b0;
        end else if (bus_mode_s) begin
            // No way back out of this state short of a reset
            state <= ST_OFF; // [RULE11]
            pull <= 1'b0;
        end else if (do_load) begin
            // A late answer sends a released byte instead of stale data
            if (ack_s == req) begin
                pull <= ~link.byte_data[BYTE_W-1]; // [RULE4] [RULE5]
                shreg <= {link.byte_data[BYTE_W-2:0], 1'b1};
            end else begin
                pull <= 1'b0;
                shreg <= ERASED_BYTE;
            end
            addr <= addr + 1'b1; // [RULE7]
            req <= ~req;
            cnt <= STREAM_CNT_W'(1);
            state <= ST_BITS;
        end else begin
            unique case (state)
                ST_SYNC: begin
                    pull <= 1'b0; // [RULE3]
                    cnt <= cnt + 1'b1; // [RULE2]
                    if (cnt == '0) begin
                        req <= ~req;
                    end
                end
                ST_BITS: begin
                    if (cnt == STREAM_CNT_W'(BITS_PER_BYTE)) begin
                        pull <= 1'b0; // [RULE6]
                        state <= ST_GAP;
                    end else begin
                        pull <= ~shreg[BYTE_W-1]; // [RULE5]
                        shreg <= {shreg[BYTE_W-2:0], 1'b1};
                        cnt <= cnt + 1'b1;
                    end
                end
                ST_GAP: begin
                    pull <= 1'b0;
                end
                ST_OFF: begin
                    pull <= 1'b0;
                end
            endcase
        end
    end

    assign link.req_toggle = req;
    assign link.req_addr = addr;
    assign link.pull_low = pull;
endmodule
`default_nettype wire

// [testbench/meid_checker.sv]
// Port checker for the monitor identification memory.
// Assumes SCL stays high in stream mode and is sampled on clk.
`timescale 1ns/1ps
`default_nettype none
module meid_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stream_clock,
    input wire logic scl_i,
    input wire logic factory_test_strap,
    input wire logic sda_oe,
    input wire logic bus_mode_active,
    input wire logic test_mode_active
);
    logic sc_q;
    logic [3:0] sedge;
    logic [7:0] scl_low_cnt;
    logic long_low;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Two flush edges precede the nine sync edges
    always_ff @(posedge clk) begin
        sc_q <= stream_clock;
        if (sys_rst) begin
            sedge <= 4'h0;
        end else if (stream_clock && !sc_q && sedge != 4'hf) begin
            sedge <= sedge + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || scl_i) begin
            scl_low_cnt <= 8'h00;
        end else if (scl_low_cnt != 8'hff) begin
            scl_low_cnt <= scl_low_cnt + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            long_low <= 1'b0;
        end else if (scl_low_cnt >= 8'h0c) begin
            long_low <= 1'b1;
        end
    end

    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !sda_oe && !bus_mode_active)
        else $error("outputs active after reset");
    // Strap is taken on the first edge after release and shows one edge later
    a_strap_sample: assert property ($fell(sys_rst) |-> ##2 test_mode_active == !factory_test_strap)
        else $error("test mode does not follow strap");
    a_test_inert: assert property (test_mode_active |-> !sda_oe)
        else $error("sda pulled in test mode");
    a_sync_quiet: assert property (!bus_mode_active && sedge < 4'hc |-> !sda_oe)
        else $error("sda pulled during sync");
    a_stream_steady: assert property (!bus_mode_active && !stream_clock && !$past(stream_clock) |-> $stable(sda_oe))
        else $error("stream bit moved in low phase");
    a_mode_sticky: assert property (bus_mode_active |=> bus_mode_active)
        else $error("bus mode left");
    a_switch_long: assert property ($rose(bus_mode_active) |-> long_low)
        else $error("bus mode on short pulse");
    a_switch_prompt: assert property (scl_low_cnt == 8'h0d && !bus_mode_active && !test_mode_active
        |-> ##[1:12] bus_mode_active)
        else $error("bus mode not entered");
    a_bus_sda_edge: assert property (bus_mode_active && $changed(sda_oe)
        |-> !scl_i && scl_low_cnt inside {[8'h02:8'h06]})
        else $error("sda moved outside scl low");

    c_bus_entry: cover property ($rose(bus_mode_active));
    c_stream_pull: cover property (!bus_mode_active && $rose(sda_oe));
    c_bus_ack: cover property (bus_mode_active && $rose(sda_oe));
endmodule
`default_nettype wire

// [testbench/meid_host_model.sv]
// Host model: makes the stream clock and acts as serial bus master.
// Assumes a pull-up on SDA; the device only pulls it low.
`timescale 1ns/1ps
`default_nettype none
module meid_host_model (
    input wire logic clk,
    input wire logic sda_oe,
    output logic stream_clock,
    output logic scl_i,
    output wire logic sda_i
);
    logic run;
    logic sda_low;

    assign sda_i = !(sda_oe || sda_low);

    initial begin
        run = 1'b1;
        sda_low = 1'b0;
        scl_i = 1'b1;
        stream_clock = 1'b0;
        #3;
        // Stands low when stopped, so nine sync edges are ours to give
        forever begin
            #62.5;
            stream_clock = run ? !stream_clock : 1'b0;
        end
    end

    task automatic hw(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic pulse_scl(input int n);
        scl_i <= 1'b0;
        hw(n);
        scl_i <= 1'b1;
        hw(1);
    endtask
    // SDA moves only with SCL low; host alone makes SCL
    task automatic clk_bit(input logic b, output logic r);
        sda_low <= !b;
        hw(12);
        scl_i <= 1'b1;
        hw(12);
        r = sda_i;
        hw(13);
        scl_i <= 1'b0;
        hw(12);
    endtask
    task automatic start_cond();
        sda_low <= 1'b0;
        hw(12);
        scl_i <= 1'b1;
        hw(12);
        sda_low <= 1'b1;
        hw(12);
        scl_i <= 1'b0;
        hw(12);
    endtask
    task automatic stop_cond();
        sda_low <= 1'b1;
        hw(12);
        scl_i <= 1'b1;
        hw(12);
        sda_low <= 1'b0;
        hw(24);
    endtask
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r[i]);
        end
        clk_bit(last, a);
        ack = !a;
    endtask
endmodule
`default_nettype wire

// [testbench/meid_top_bench.sv]
// Top bench: programs the memory in bus mode, then reads it back as a stream.
// Assumes the host model makes both link clocks and resolves SDA.
`timescale 1ns/1ps
`default_nettype none
module meid_top_bench;
    import meid_pkg::*;
    logic clk, sys_rst, write_protect_low, factory_test_strap;
    wire logic stream_clock, scl_i, sda_i;
    logic sda_o, sda_oe, bus_mode_active, test_mode_active;
    logic [7:0] rd;
    logic ack, v;
    int failures = 0;
    int cmp_count = 0;

    meid_top dut (.clk(clk), .sys_rst(sys_rst), .stream_clock(stream_clock), .scl_i(scl_i), .sda_i(sda_i),
        .write_protect_low(write_protect_low), .factory_test_strap(factory_test_strap), .sda_o(sda_o),
        .sda_oe(sda_oe), .bus_mode_active(bus_mode_active), .test_mode_active(test_mode_active));
    meid_host_model host (.clk(clk), .sda_oe(sda_oe), .stream_clock(stream_clock), .scl_i(scl_i), .sda_i(sda_i));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Stream side resyncs reset on its own clock, so it must run meanwhile
    task automatic do_reset(input logic strap);
        host.run = 1'b1;
        @(posedge clk);
        factory_test_strap <= strap;
        sys_rst <= 1'b1;
        repeat (6) @(posedge clk);
        repeat (3) @(posedge stream_clock);
        @(negedge stream_clock);
        @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic sbit(output logic b);
        @(posedge stream_clock);
        @(negedge stream_clock);
        b = sda_i;
    endtask
    task automatic sbyte(input logic [7:0] exp);
        logic [7:0] b;
        logic g;
        for (int i = 7; i >= 0; i--) begin
            sbit(b[i]);
        end
        sbit(g);
        chk("stream byte", exp, b);
        chk("gap bit", 8'h01, {7'h0, g});
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [23:0] d, input int n);
        host.start_cond();
        host.xbyte({SLAVE_ADDR, 1'b0}, 1'b1, rd, ack);
        chk("addr ack", 8'h01, {7'h0, ack});
        host.xbyte(a, 1'b1, rd, ack);
        chk("word ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            host.xbyte(d[23-8*i -: 8], 1'b1, rd, ack);
            chk("data ack", 8'h01, {7'h0, ack});
        end
        host.stop_cond();
    endtask
    task automatic bus_read(input logic [7:0] a, input logic [23:0] exp, input int n);
        host.start_cond();
        host.xbyte({SLAVE_ADDR, 1'b0}, 1'b1, rd, ack);
        host.xbyte(a, 1'b1, rd, ack);
        host.start_cond();
        host.xbyte({SLAVE_ADDR, 1'b1}, 1'b1, rd, ack);
        chk("read ack", 8'h01, {7'h0, ack});
        for (int i = 0; i < n; i++) begin
            host.xbyte(8'hff, i == n - 1, rd, ack);
            chk("read data", exp[23-8*i -: 8], rd);
        end
        host.stop_cond();
    endtask

    task automatic t_switch();
        do_reset(1'b1);
        chk("bus mode", 8'h00, {7'h0, bus_mode_active});
        chk("test mode", 8'h00, {7'h0, test_mode_active});
        host.pulse_scl(8);
        repeat (40) @(posedge clk);
        chk("short pulse", 8'h00, {7'h0, bus_mode_active});
        host.pulse_scl(50);
        repeat (30) @(posedge clk);
        chk("long pulse", 8'h01, {7'h0, bus_mode_active});
        host.run = 1'b0;
        $display("switch test done");
    endtask
    task automatic t_bus();
        // Three bytes from 0x7f wrap the pointer to 0x00
        bus_write(8'h7f, 24'h5aa53c, 3);
        bus_read(8'h7f, 24'h5aa53c, 3);
        host.start_cond();
        host.xbyte({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, rd, ack);
        host.stop_cond();
        chk("foreign addr", 8'h00, {7'h0, ack});
        write_protect_low <= 1'b0;
        bus_write(8'h10, 24'h000000, 1);
        write_protect_low <= 1'b1;
        bus_read(8'h10, 24'hff0000, 1);
        host.run = 1'b1;
        bus_write(8'h11, 24'h770000, 1);
        bus_read(8'h11, 24'h770000, 1);
        chk("mode kept", 8'h01, {7'h0, bus_mode_active});
        host.run = 1'b0;
        $display("bus test done");
    endtask
    task automatic t_stream();
        do_reset(1'b1);
        sbit(v);
        sbit(v);
        for (int i = 0; i < 9; i++) begin
            sbit(v);
            chk("sync bit", 8'h01, {7'h0, v});
        end
        sbyte(8'ha5);
        sbyte(8'h3c);
        chk("sda out level", 8'h00, {7'h0, sda_o});
        for (int i = 2; i < 127; i++) begin
            sbyte(i == 17 ? 8'h77 : 8'hff);
        end
        sbyte(8'h5a);
        sbyte(8'ha5);
        $display("stream test done");
    endtask
    task automatic t_test();
        do_reset(1'b0);
        chk("test mode", 8'h01, {7'h0, test_mode_active});
        for (int i = 0; i < 30; i++) begin
            sbit(v);
            chk("test sda", 8'h01, {7'h0, v});
        end
        $display("strap test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    initial begin
        repeat (80000) @(posedge clk);
        failures++;
        $display("[ERR] watchdog expected end seen hang");
        close_out();
    end
    initial begin
        sys_rst = 1'b1;
        write_protect_low = 1'b1;
        factory_test_strap = 1'b1;
        t_switch();
        t_bus();
        t_stream();
        t_test();
        close_out();
    end
endmodule

bind meid_top meid_checker u_checker (.clk(clk), .sys_rst(sys_rst), .stream_clock(stream_clock), .scl_i(scl_i),
    .factory_test_strap(factory_test_strap), .sda_oe(sda_oe), .bus_mode_active(bus_mode_active),
    .test_mode_active(test_mode_active));
`default_nettype wire
